//--- svca_pkg.sv
// svca_pkg: shared constants and carrier types for the synthesizer control block
// assumes a single core_clk domain at 25 MHz
`default_nettype none
package svca_pkg;
  localparam int FREQ_W = 32;            // carrier word, 1 Hz per step
  localparam int RANGE_W = 4;            // vco range code width
  localparam int CP_W = 8;               // charge pump current width
  localparam int LOOP_W = 8;             // loop config width
  localparam int BOOST_W = 16;           // boost duration counter width
  localparam logic [RANGE_W-1:0] RANGE_RESET = 4'h8;
  localparam logic [RANGE_W-1:0] RANGE_MAX = 4'hF;
  localparam logic [1:0] FLT_BYPASS = 2'h0;
  localparam int CLK_HZ = 25000000;
  localparam int SETTLE_NS = 1000;       // settle time per ranging step
  localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [BOOST_W-1:0] BOOST_RESET = 16'h0019;

  typedef enum logic [1:0] {
    SVCA_MODE_INT = 2'h0,
    SVCA_MODE_EXT_IND = 2'h1,
    SVCA_MODE_EXT_VCO = 2'h2
  } svca_mode_t;

  typedef enum logic [1:0] {
    SVCA_IDLE = 2'h0,
    SVCA_SETTLE = 2'h1,
    SVCA_JUDGE = 2'h2
  } svca_state_t;

  typedef struct packed {
    logic output_divider_bit;
    logic inductor_path_select;
    logic vco_source_select;
  } svca_vcodiv_t;

  typedef struct packed {
    logic [1:0] loop_filter_select;
    logic [LOOP_W-3:0] loop_bw;
  } svca_loop_t;
endpackage : svca_pkg
`default_nettype wire

//--- svca_boost.sv
// svca_boost: chooses boost or normal loop settings after synthesizer start
// assumes synth_start is a one-cycle pulse on core_clk
`default_nettype none
module svca_boost (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic synth_start,
  input wire logic [svca_pkg::BOOST_W-1:0] boost_cycles,
  input wire svca_pkg::svca_loop_t boost_loop_config,
  input wire logic [svca_pkg::CP_W-1:0] boost_pump_current,
  input wire svca_pkg::svca_loop_t normal_loop_config,
  input wire logic [svca_pkg::CP_W-1:0] normal_pump_current,
  output svca_pkg::svca_loop_t loop_cfg,
  output logic [svca_pkg::CP_W-1:0] pump_cfg,
  output logic filter_bypass
);
  logic [svca_pkg::BOOST_W-1:0] cnt_q, cnt_d;
  svca_pkg::svca_loop_t loop_q, loop_d;
  logic [svca_pkg::CP_W-1:0] pump_q, pump_d;
  logic byp_q, byp_d;

  // boost window counter, restarted on every start
  always_comb begin
    cnt_d = cnt_q;
    if (synth_start) begin
      cnt_d = boost_cycles;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - 16'h0001;
    end
    loop_d = (cnt_d != '0) ? boost_loop_config : normal_loop_config;
    pump_d = (cnt_d != '0) ? boost_pump_current : normal_pump_current;
    byp_d = (loop_d.loop_filter_select == svca_pkg::FLT_BYPASS);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      loop_q <= '0;
      pump_q <= '0;
      byp_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      loop_q <= loop_d;
      pump_q <= pump_d;
      byp_q <= byp_d;
    end
  end

  assign loop_cfg = loop_q;
  assign pump_cfg = pump_q;
  assign filter_bypass = byp_q;
endmodule : svca_boost
`default_nettype wire

//--- svca_top.sv
// svca_top: carrier words, vco source selection and vco auto-ranging
// assumes software pulses write strobes on core_clk; vco_too_fast is an async comparator
`default_nettype none
module svca_top #(
  parameter int FREQ_W = svca_pkg::FREQ_W,
  parameter int RANGE_W = svca_pkg::RANGE_W
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic freq_a_wr,
  input wire logic freq_b_wr,
  input wire logic [FREQ_W-1:0] freq_wdata,
  input wire logic vcodiv_wr,
  input wire svca_pkg::svca_vcodiv_t vcodiv_wdata,
  input wire logic ranging_a_wr,
  input wire logic ranging_b_wr,
  input wire logic range_start_wdata,
  input wire logic use_freq_b,
  input wire logic synth_start,
  input wire logic [svca_pkg::BOOST_W-1:0] boost_cycles,
  input wire svca_pkg::svca_loop_t boost_loop_config,
  input wire logic [svca_pkg::CP_W-1:0] boost_pump_current,
  input wire svca_pkg::svca_loop_t normal_loop_config,
  input wire logic [svca_pkg::CP_W-1:0] normal_pump_current,
  input wire logic vco_too_fast,
  output logic [FREQ_W-1:0] carrier_freq_a,
  output logic [FREQ_W-1:0] carrier_freq_b,
  output svca_pkg::svca_vcodiv_t vco_divider_config,
  output svca_pkg::svca_mode_t vco_mode,
  output logic [FREQ_W-1:0] synth_freq,
  output logic [FREQ_W-1:0] ranging_freq,
  output logic [RANGE_W-1:0] vco_range,
  output logic range_start_a,
  output logic range_start_b,
  output logic range_error_flag,
  output svca_pkg::svca_loop_t loop_cfg,
  output logic [svca_pkg::CP_W-1:0] pump_cfg,
  output logic filter_bypass
);
  localparam logic [7:0] SETTLE_LD = 8'(svca_pkg::SETTLE_CYC);

  // configuration registers
  logic [FREQ_W-1:0] fa_q, fa_d, fb_q, fb_d;
  svca_pkg::svca_vcodiv_t div_q, div_d;

  // ranging engine state
  svca_pkg::svca_state_t st_q, st_d;
  logic sel_b_q, sel_b_d;
  logic [RANGE_W-1:0] rng_q, rng_d;
  logic [RANGE_W-1:0] step_q, step_d;
  logic [7:0] tmr_q, tmr_d;
  logic err_q, err_d;
  logic busy;
  logic start_req;

  // pin synchroniser: a change counts when stages 2 and 3 agree
  logic fast_s1_q, fast_s2_q, fast_s3_q, fast_q, fast_d;

  // ranging is refused in fully external vco mode
  function automatic logic range_ok(input svca_pkg::svca_vcodiv_t d);
    range_ok = !(d.vco_source_select && !d.inductor_path_select);
  endfunction : range_ok

  always_comb begin
    fa_d = fa_q;
    fb_d = fb_q;
    div_d = div_q;
    if (freq_a_wr) begin
      fa_d = freq_wdata;
    end
    if (freq_b_wr) begin
      fb_d = freq_wdata;
    end
    if (vcodiv_wr) begin
      div_d = vcodiv_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fa_q <= '0;
      fb_q <= '0;
      div_q <= '0;
    end else begin
      fa_q <= fa_d;
      fb_q <= fb_d;
      div_q <= div_d;
    end
  end

  // mode decode from source and inductor selects
  always_comb begin
    if (!div_q.vco_source_select) begin
      vco_mode = svca_pkg::SVCA_MODE_INT;
    end else if (div_q.inductor_path_select) begin
      vco_mode = svca_pkg::SVCA_MODE_EXT_IND;
    end else begin
      vco_mode = svca_pkg::SVCA_MODE_EXT_VCO;
    end
  end

  // synchroniser chain; stage 1 feeds only stage 2
  always_comb begin
    fast_d = (fast_s2_q == fast_s3_q) ? fast_s3_q : fast_q;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      fast_s1_q <= 1'b0;
      fast_s2_q <= 1'b0;
      fast_s3_q <= 1'b0;
      fast_q <= 1'b0;
    end else begin
      fast_s1_q <= vco_too_fast;
      fast_s2_q <= fast_s1_q;
      fast_s3_q <= fast_s2_q;
      fast_q <= fast_d;
    end
  end

  assign busy = (st_q != svca_pkg::SVCA_IDLE);
  assign start_req = range_start_wdata && (ranging_a_wr || ranging_b_wr);

  // binary search of vco range; settle wait covers the synchroniser delay
  always_comb begin
    st_d = st_q;
    sel_b_d = sel_b_q;
    rng_d = rng_q;
    step_d = step_q;
    tmr_d = tmr_q;
    err_d = err_q;
    case (st_q)
      svca_pkg::SVCA_IDLE: begin
        if (start_req) begin
          sel_b_d = ranging_b_wr && !ranging_a_wr;
          if (range_ok(div_q)) begin
            st_d = svca_pkg::SVCA_SETTLE;
            rng_d = svca_pkg::RANGE_RESET;
            step_d = svca_pkg::RANGE_RESET >> 1;
            tmr_d = SETTLE_LD;
            err_d = 1'b0;
          end else begin
            err_d = 1'b1;
          end
        end
      end
      svca_pkg::SVCA_SETTLE: begin
        if (tmr_q <= 8'h01) begin
          st_d = svca_pkg::SVCA_JUDGE;
        end else begin
          tmr_d = tmr_q - 8'h01;
        end
      end
      svca_pkg::SVCA_JUDGE: begin
        if (step_q == '0) begin
          // search never reaches code 0, so code 1 is its low end; an end code
          // still off target means no range fits
          err_d = (fast_q && rng_q == RANGE_W'(1)) ||
            (!fast_q && rng_q == svca_pkg::RANGE_MAX);
          st_d = svca_pkg::SVCA_IDLE;
        end else begin
          rng_d = fast_q ? rng_q - step_q : rng_q + step_q;
          step_d = step_q >> 1;
          tmr_d = SETTLE_LD;
          st_d = svca_pkg::SVCA_SETTLE;
        end
      end
      default: begin
        st_d = svca_pkg::SVCA_IDLE;
      end
    endcase
  end

  // run in progress ignores further start writes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= svca_pkg::SVCA_IDLE;
      sel_b_q <= 1'b0;
      rng_q <= svca_pkg::RANGE_RESET;
      step_q <= '0;
      tmr_q <= '0;
      err_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sel_b_q <= sel_b_d;
      rng_q <= rng_d;
      step_q <= step_d;
      tmr_q <= tmr_d;
      err_q <= err_d;
    end
  end

  // status and frequency outputs
  assign carrier_freq_a = fa_q;
  assign carrier_freq_b = fb_q;
  assign vco_divider_config = div_q;
  assign ranging_freq = sel_b_q ? fb_q : fa_q;
  assign synth_freq = use_freq_b ? fb_q : fa_q;
  assign vco_range = rng_q;
  assign range_start_a = busy && !sel_b_q;
  assign range_start_b = busy && sel_b_q;
  assign range_error_flag = err_q;

  svca_boost u_boost (
    .core_clk(core_clk),
    .rstn(rstn),
    .synth_start(synth_start),
    .boost_cycles(boost_cycles),
    .boost_loop_config(boost_loop_config),
    .boost_pump_current(boost_pump_current),
    .normal_loop_config(normal_loop_config),
    .normal_pump_current(normal_pump_current),
    .loop_cfg(loop_cfg),
    .pump_cfg(pump_cfg),
    .filter_bypass(filter_bypass)
  );
endmodule : svca_top
`default_nettype wire

//--- svca_monitor.sv
// svca_monitor: port-level assertions for svca_top
// assumes one core_clk domain and async active-low rstn
`default_nettype none
module svca_monitor #(
  parameter int FREQ_W = 32,
  parameter int RANGE_W = 4
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic freq_a_wr,
  input wire logic [FREQ_W-1:0] freq_wdata,
  input wire logic ranging_a_wr,
  input wire logic ranging_b_wr,
  input wire logic range_start_wdata,
  input wire logic [FREQ_W-1:0] carrier_freq_a,
  input wire logic [FREQ_W-1:0] carrier_freq_b,
  input wire svca_pkg::svca_vcodiv_t vco_divider_config,
  input wire svca_pkg::svca_mode_t vco_mode,
  input wire logic [FREQ_W-1:0] ranging_freq,
  input wire logic [RANGE_W-1:0] vco_range,
  input wire logic range_start_a,
  input wire logic range_start_b,
  input wire logic range_error_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic busy, go, ext, ind, src;
  // go is a start write on control a while idle
  assign busy = range_start_a | range_start_b;
  assign go = ranging_a_wr & range_start_wdata & !busy;
  assign ext = vco_mode == svca_pkg::SVCA_MODE_EXT_VCO;
  assign ind = vco_divider_config.inductor_path_select;
  assign src = vco_divider_config.vco_source_select;
  freq_load_a: assert property (freq_a_wr |=> carrier_freq_a == $past(freq_wdata))
    else $error("word a not loaded");
  ext_ind_mode_a: assert property (ind && src |-> vco_mode == svca_pkg::SVCA_MODE_EXT_IND)
    else $error("inductor mode wrong");
  ext_vco_mode_a: assert property (!ind && src |-> ext)
    else $error("external vco mode wrong");
  start_run_a: assert property (go && !ext |=> range_start_a)
    else $error("run a not started");
  run_bound_a: assert property ($rose(busy) |-> ##90 busy ##[1:30] !busy)
    else $error("run length wrong");
  range_a_freq_a: assert property (range_start_a |-> ranging_freq == carrier_freq_a)
    else $error("run a ranges wrong word");
  range_b_freq_a: assert property (range_start_b |-> ranging_freq == carrier_freq_b)
    else $error("run b ranges wrong word");
  refused_ext_a: assert property (go && ext |-> ##2 range_error_flag && !busy)
    else $error("external vco start not flagged");
  hold_result_a: assert property (!busy && !$past(busy) && !ranging_a_wr && !ranging_b_wr
    |=> $stable(range_error_flag) && $stable(vco_range)) else $error("result moved");
  no_restart_a: assert property (range_start_a && ranging_b_wr |=> !range_start_b)
    else $error("start in run taken");
endmodule : svca_monitor
bind svca_top svca_monitor #(.FREQ_W(FREQ_W), .RANGE_W(RANGE_W)) u_svca_monitor (.*);
`default_nettype wire

//--- tb.sv
// tb: directed sequences for the synthesizer control block
// assumes svca_pkg, svca_top and svca_monitor are compiled first
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0, rstn = 1'h0, freq_a_wr = 1'h0, freq_b_wr = 1'h0;
  logic vcodiv_wr = 1'h0, synth_start = 1'h0, ranging_a_wr = 1'h0, ranging_b_wr = 1'h0;
  logic range_start_wdata = 1'h1, use_freq_b = 1'h0, vco_too_fast = 1'h0;
  logic [31:0] freq_wdata = 32'h0, fa = 32'h19CF0E40, fb = 32'h33BCA100;
  svca_pkg::svca_vcodiv_t vcodiv_wdata = 3'h0, vco_divider_config;
  svca_pkg::svca_vcodiv_t vd[3] = '{3'h1, 3'h0, 3'h7};
  svca_pkg::svca_mode_t vco_mode;
  svca_pkg::svca_mode_t vm[3] = '{svca_pkg::SVCA_MODE_EXT_VCO, svca_pkg::SVCA_MODE_INT,
    svca_pkg::SVCA_MODE_EXT_IND};
  logic [15:0] boost_cycles = 16'h4;
  svca_pkg::svca_loop_t boost_loop_config = 8'h05, normal_loop_config = 8'h49, loop_cfg;
  logic [7:0] boost_pump_current = 8'hA0, normal_pump_current = 8'h10, pump_cfg;
  logic [31:0] carrier_freq_a, carrier_freq_b, synth_freq, ranging_freq;
  logic [3:0] vco_range, tgt = 4'h5, held;
  logic range_start_a, range_start_b, range_error_flag, filter_bypass;
  int n_fail = 0, cmp_count = 0;

  svca_top u_svca_top (.*);

  initial forever #20 core_clk = ~core_clk;
  // comparator stand-in: too fast while the code sits above the target
  always @(negedge core_clk) vco_too_fast <= vco_range > tgt;

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one write to ranging control a or b; leading tick keeps strobes apart
  task automatic rng(input logic b, input logic [3:0] t);
    tick(1);
    tgt = t;
    ranging_a_wr = !b;
    ranging_b_wr = b;
    tick(1);
    ranging_a_wr = 1'h0;
    ranging_b_wr = 1'h0;
  endtask : rng
  // bounded poll of the start bits, then the run's outcome
  task automatic finish_run(input logic e);
    for (int i = 0; i < 200 && (range_start_a | range_start_b); i++) tick(1);
    chk(range_start_a | range_start_b, 0);
    chk(range_error_flag, e);
    chk(vco_range - tgt <= 4'h1, 1);
  endtask : finish_run
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // main sequence: reset, words, modes, ranging runs, boost window
  initial begin
    tick(12);
    rstn = 1'h1;
    chk(vco_range, 4'h8);
    chk(filter_bypass, 1);
    freq_wdata = fa;
    freq_a_wr = 1'h1;
    tick(1);
    freq_a_wr = 1'h0;
    freq_wdata = fb;
    freq_b_wr = 1'h1;
    tick(1);
    freq_b_wr = 1'h0;
    tick(1);
    chk(carrier_freq_a, fa);
    chk(carrier_freq_b, fb);
    chk(synth_freq, fa);
    use_freq_b = 1'h1;
    tick(1);
    chk(synth_freq, fb);
    for (int k = 0; k < 3; k++) begin
      vcodiv_wdata = vd[k];
      vcodiv_wr = 1'h1;
      tick(1);
      vcodiv_wr = 1'h0;
      chk(vco_divider_config, vd[k]);
      chk(vco_mode, vm[k]);
      if (k == 0) begin
        rng(0, 4'h5);
        tick(1);
        chk(range_error_flag, 1);
        chk(range_start_a, 0);
      end
    end
    range_start_wdata = 1'h0;
    rng(0, 4'h5);
    range_start_wdata = 1'h1;
    chk(range_start_a, 0);
    rng(0, 4'h5);
    chk(range_start_a, 1);
    chk(ranging_freq, fa);
    rng(1, 4'h5);
    chk(range_start_b, 0);
    chk(range_start_a, 1);
    finish_run(1'h0);
    held = vco_range;
    tick(20);
    chk(vco_range, held);
    rng(1, 4'hC);
    chk(range_start_b, 1);
    chk(ranging_freq, fb);
    finish_run(1'h0);
    // comparator still too fast at the lowest code the search reaches
    rng(0, 4'h0);
    finish_run(1'h1);
    // comparator never too fast: top code still slow
    rng(1, 4'hF);
    chk(range_error_flag, 0);
    finish_run(1'h1);
    synth_start = 1'h1;
    tick(1);
    synth_start = 1'h0;
    tick(1);
    chk(loop_cfg, boost_loop_config);
    chk(pump_cfg, boost_pump_current);
    chk(filter_bypass, 1);
    tick(8);
    chk(loop_cfg, normal_loop_config);
    chk(pump_cfg, normal_pump_current);
    chk(filter_bypass, 0);
    summarize;
  end

  // watchdog: the sequence needs well under 1000 cycles
  initial begin
    tick(2000);
    n_fail++;
    summarize;
  end
endmodule : tb
`default_nettype wire
